// ---- rtl/mihd_detect.sv ----
// mic insertion and hook switch event flags with optional debounce and pin output
//
// How it works
// - With insertion debounce enabled the insertion level is filtered before use.
// - A press counts only after ten consecutive samples above the hook threshold.
// - A release counts only after ten consecutive samples below the hook threshold.
// - With hook debounce enabled the hook level is filtered further before use.
// - The detection results can be shown on a general purpose pin.
// - The pin shows the steady state after the same detection delays.
`timescale 1ns/1ps
module mihd_detect
   import mihd_pkg::*;
#(
   parameter int HOOK_SAMPLES    = MIHD_HOOK_SAMPLES,
   parameter int DEBOUNCE_CYCLES = MIHD_DEBOUNCE_CYCLES,
   parameter int SAMPLE_DIV      = MIHD_SAMPLE_DIV
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic clk_en,
   input  wire logic insert_raw,
   input  wire logic hook_raw,
   input  wire logic insert_irq_polarity,
   input  wire logic hook_irq_polarity,
   input  wire logic insert_debounce_en,
   input  wire logic hook_debounce_en,
   input  wire logic insert_irq_clear,
   input  wire logic hook_irq_clear,
   input  wire logic gpio_sel_hook,
   output logic      insert_irq_flag,
   output logic      hook_irq_flag,
   output logic      insert_state,
   output logic      hook_state,
   output logic      gpio_out
);
   localparam int CNT_W = 5;
   localparam int DIV_W = 8;

   logic [DIV_W-1:0] div_ff, nxt_div;
   logic             sample_ff, nxt_sample;
   logic             ins_db, hook_q, hook_db;
   logic             ins_lvl, hook_lvl;
   logic             ins_prev_ff, nxt_ins_prev, hook_prev_ff, nxt_hook_prev;
   logic             ins_flag_ff, nxt_ins_flag, hook_flag_ff, nxt_hook_flag;
   logic             gpio_ff, nxt_gpio, ins_st_ff, hook_st_ff;
   logic             ins_hit, hook_hit;

   // sample strobe for the bias current comparators
   always_comb begin
      nxt_div    = div_ff + 1'b1;
      nxt_sample = 1'b0;
      if (div_ff >= DIV_W'(SAMPLE_DIV - 1)) begin
         nxt_div    = '0;
         nxt_sample = 1'b1;
      end
   end

   mihd_filter #(.CNT_W(CNT_W)) u_ins_db (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .clk_en     (clk_en),
      .sample_en  (sample_ff),
      .raw_in     (insert_raw),
      .need       (CNT_W'(DEBOUNCE_CYCLES)),
      .stable_out (ins_db)
   );

   mihd_filter #(.CNT_W(CNT_W)) u_hook_q (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .clk_en     (clk_en),
      .sample_en  (sample_ff),
      .raw_in     (hook_raw),
      .need       (CNT_W'(HOOK_SAMPLES)),
      .stable_out (hook_q)
   );

   mihd_filter #(.CNT_W(CNT_W)) u_hook_db (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .clk_en     (clk_en),
      .sample_en  (sample_ff),
      .raw_in     (hook_q),
      .need       (CNT_W'(DEBOUNCE_CYCLES)),
      .stable_out (hook_db)
   );

   // debounce adds delay, so it is optional per event
   assign ins_lvl  = insert_debounce_en ? ins_db : insert_raw;
   assign hook_lvl = hook_debounce_en ? hook_db : hook_q;

   // edge toward the selected polarity; level trigger would refire after clear
   assign ins_hit  = (ins_lvl != ins_prev_ff) &&
                     (ins_lvl == (insert_irq_polarity == MIHD_POL_PRESENT));
   assign hook_hit = (hook_lvl != hook_prev_ff) &&
                     (hook_lvl == (hook_irq_polarity == MIHD_POL_PRESENT));

   always_comb begin
      nxt_ins_prev  = ins_lvl;
      nxt_hook_prev = hook_lvl;
      // set wins over a clear in the same cycle
      nxt_ins_flag  = ins_hit | (ins_flag_ff & ~insert_irq_clear);
      nxt_hook_flag = hook_hit | (hook_flag_ff & ~hook_irq_clear);
      nxt_gpio      = gpio_sel_hook ? hook_lvl : ins_lvl;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_ff       <= '0;
         sample_ff    <= 1'b0;
         ins_prev_ff  <= MIHD_PIN_RST;
         hook_prev_ff <= MIHD_PIN_RST;
         ins_flag_ff  <= MIHD_FLAG_RST;
         hook_flag_ff <= MIHD_FLAG_RST;
         gpio_ff      <= MIHD_PIN_RST;
         ins_st_ff    <= MIHD_PIN_RST;
         hook_st_ff   <= MIHD_PIN_RST;
      end else if (clk_en) begin
         div_ff       <= nxt_div;
         sample_ff    <= nxt_sample;
         ins_prev_ff  <= nxt_ins_prev;
         hook_prev_ff <= nxt_hook_prev;
         ins_flag_ff  <= nxt_ins_flag;
         hook_flag_ff <= nxt_hook_flag;
         gpio_ff      <= nxt_gpio;
         ins_st_ff    <= ins_lvl;
         hook_st_ff   <= hook_lvl;
      end
   end

   assign insert_irq_flag = ins_flag_ff;
   assign hook_irq_flag   = hook_flag_ff;
   assign insert_state    = ins_st_ff;
   assign hook_state      = hook_st_ff;
   assign gpio_out        = gpio_ff;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   sequence ins_event_s;
      clk_en && ins_hit;
   endsequence

   flag_set_ins_a: assert property (ins_event_s |=> insert_irq_flag)
      else $error("insert flag missed its event");
   flag_set_hook_a: assert property (clk_en && hook_hit |=> hook_irq_flag)
      else $error("hook flag missed its event");
   flag_hold_a: assert property (clk_en && insert_irq_flag && !insert_irq_clear
                                 |=> insert_irq_flag)
      else $error("insert flag dropped without clear");
   flag_clear_a: assert property (clk_en && hook_irq_clear && !hook_hit
                                  |=> !hook_irq_flag)
      else $error("hook flag survived clear");
   no_spurious_a: assert property (clk_en && !hook_hit && !hook_irq_flag
                                   |=> !hook_irq_flag)
      else $error("hook flag set without event");
   pol_present_a: assert property (clk_en && ins_hit && !insert_irq_polarity
                                   |-> ins_lvl)
      else $error("insert polarity zero fired on removal");
   // the last sample of the run is two edges back: take state sits between
   hook_qual_a: assert property (clk_en && !hook_debounce_en && $changed(hook_q)
                                 |-> $past(hook_raw, 2) == hook_q)
      else $error("hook level changed against raw");
   gpio_follow_a: assert property (clk_en && !gpio_sel_hook |=> gpio_out == $past(ins_lvl))
      else $error("gpio not following insert state");
   ins_bypass_a: assert property (!insert_debounce_en |-> ins_lvl == insert_raw)
      else $error("insert debounce not bypassed");

   sequence hook_event_s;
      clk_en && hook_hit;
   endsequence

   sequence ins_quiet_s;
      clk_en && !ins_hit && !insert_irq_flag;
   endsequence

   gpio_hook_a: assert property (clk_en && gpio_sel_hook |=> gpio_out == $past(hook_lvl))
      else $error("gpio not following hook state");
   ins_state_a: assert property (clk_en |=> insert_state == $past(ins_lvl))
      else $error("insert state not following level");
   hook_state_a: assert property (clk_en |=> hook_state == $past(hook_lvl))
      else $error("hook state not following level");
   ins_clear_a: assert property (clk_en && insert_irq_clear && !ins_hit
                                 |=> !insert_irq_flag)
      else $error("insert flag survived clear");
   hook_hold_a: assert property (clk_en && hook_irq_flag && !hook_irq_clear
                                 |=> hook_irq_flag)
      else $error("hook flag dropped without clear");
   ins_spurious_a: assert property (ins_quiet_s |=> !insert_irq_flag)
      else $error("insert flag set without event");
   hook_dir_a: assert property (hook_event_s |-> hook_lvl == !hook_irq_polarity)
      else $error("hook event against polarity");
   ins_dir_a: assert property (clk_en && ins_hit |-> ins_lvl == !insert_irq_polarity)
      else $error("insert event against polarity");
   freeze_flags_a: assert property (!clk_en |=> $stable(insert_irq_flag)
                                    && $stable(hook_irq_flag))
      else $error("flags moved while frozen");
   hook_bypass_a: assert property (!hook_debounce_en |-> hook_lvl == hook_q)
      else $error("hook debounce not bypassed");
endmodule

// ---- rtl/mihd_filter.sv ----
// qualifier: a raw level must hold for a number of samples before it is accepted
`timescale 1ns/1ps
module mihd_filter
   import mihd_pkg::*;
#(
   parameter int CNT_W = 4
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   input  wire logic             sample_en,
   input  wire logic             raw_in,
   input  wire logic [CNT_W-1:0] need,
   output logic                  stable_out
);
   mihd_state_e      state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic             stable_ff, nxt_stable;

   always_comb begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_stable = stable_ff;
      case (state_ff)
         MIHD_IDLE: begin
            if (sample_en && raw_in != stable_ff) begin
               nxt_cnt   = {{(CNT_W-1){1'b0}}, 1'b1};
               nxt_state = (need <= 1) ? MIHD_TAKE : MIHD_COUNT;
            end
         end
         MIHD_COUNT: begin
            // any sample back at the old level restarts the run
            if (sample_en) begin
               if (raw_in == stable_ff) begin
                  nxt_state = MIHD_IDLE;
               end else begin
                  nxt_cnt = cnt_ff + 1'b1;
                  if (nxt_cnt >= need) begin
                     nxt_state = MIHD_TAKE;
                  end
               end
            end
         end
         MIHD_TAKE: begin
            nxt_stable = ~stable_ff;
            nxt_state  = MIHD_IDLE;
         end
         default: nxt_state = MIHD_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff  <= MIHD_IDLE;
         cnt_ff    <= '0;
         stable_ff <= MIHD_PIN_RST;
      end else if (clk_en) begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         stable_ff <= nxt_stable;
      end
   end

   assign stable_out = stable_ff;
endmodule

// ---- rtl/mihd_pkg.sv ----
// constants for the mic insert and hook detect event block
package mihd_pkg;
   localparam int MIHD_HOOK_SAMPLES    = 10;
   localparam int MIHD_DEBOUNCE_CYCLES = 4;
   localparam int MIHD_SAMPLE_DIV      = 1;
   localparam logic MIHD_FLAG_RST      = 1'b0;
   localparam logic MIHD_PIN_RST       = 1'b0;
   localparam logic MIHD_POL_PRESENT   = 1'b0;
   typedef enum logic [2:0] {
      MIHD_IDLE  = 3'b001,
      MIHD_COUNT = 3'b010,
      MIHD_TAKE  = 3'b100
   } mihd_state_e;
endpackage

// ---- verif/mihd_detect_tb.sv ----
// self-checking bench for the insert and hook event flags
`timescale 1ns/1ps
module mihd_detect_tb;
   import mihd_pkg::*;
   localparam int HS = MIHD_HOOK_SAMPLES;
   localparam int DB = MIHD_DEBOUNCE_CYCLES;
   logic       core_clk = 0, rst_b = 0, ins_raw = 0, hook_raw = 0, ins_db = 0, hook_db = 0;
   logic       gsel = 0, auto_en = 0, slow = 0, tp_i = 0, tc_i = 0, tp_h = 0, tc_h = 0, ce = 1;
   logic       ins_pol, ins_clr, hk_pol, hk_clr, ins_flag, hk_flag, ins_st, hk_st, gpio;
   logic [4:0] r;
   int         fail_count = 0, total_checks = 0, cycles = 0, n;
   // row bits: hook channel, polarity, from level, to level, expected flag
   logic [4:0] rows [8] = '{5'h03, 5'h04, 5'h0a, 5'h0d, 5'h13, 5'h14, 5'h1a, 5'h1d};
   always #50 core_clk = ~core_clk;
   mihd_detect DUT (.core_clk(core_clk), .rst_b(rst_b), .clk_en(ce), .insert_raw(ins_raw),
      .hook_raw(hook_raw), .insert_irq_polarity(ins_pol), .hook_irq_polarity(hk_pol),
      .insert_debounce_en(ins_db), .hook_debounce_en(hook_db), .insert_irq_clear(ins_clr),
      .hook_irq_clear(hk_clr), .gpio_sel_hook(gsel), .insert_irq_flag(ins_flag),
      .hook_irq_flag(hk_flag), .insert_state(ins_st), .hook_state(hk_st), .gpio_out(gpio));
   mihd_host HI (.core_clk(core_clk), .rst_b(rst_b), .auto_en(auto_en), .slow(slow),
      .flag(ins_flag), .tb_pol(tp_i), .tb_clr(tc_i), .pol(ins_pol), .clr(ins_clr));
   mihd_host HH (.core_clk(core_clk), .rst_b(rst_b), .auto_en(auto_en), .slow(slow),
      .flag(hk_flag), .tb_pol(tp_h), .tb_clr(tc_h), .pol(hk_pol), .clr(hk_clr));
   task automatic chk(string nm, logic e, logic g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge core_clk);
   endtask
   // clear goes through the host model, so it lands one cycle late
   task automatic clr2;
      @(posedge core_clk);
      tc_i <= 1'b1;
      tc_h <= 1'b1;
      @(posedge core_clk);
      tc_i <= 1'b0;
      tc_h <= 1'b0;
      cyc(2);
   endtask
   task automatic lat(bit hk);
      n = 0;
      while ((hk ? hk_flag : ins_flag) !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      cyc(6);
      chk("outputs in reset", 1'b0, ins_flag | hk_flag | gpio | ins_st | hk_st);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         gsel <= r[4];
         tp_i <= r[3];
         tp_h <= r[3];
         if (r[4]) hook_raw <= r[2];
         else ins_raw <= r[2];
         cyc(25);
         clr2();
         if (r[4]) hook_raw <= r[1];
         else ins_raw <= r[1];
         cyc(25);
         @(negedge core_clk);
         chk("row flag", r[0], r[4] ? hk_flag : ins_flag);
         chk("row state", r[1], r[4] ? hk_st : ins_st);
         chk("gpio", r[1], gpio);
         @(posedge core_clk);
      end
      for (int d = 0; d < 2; d++) begin
         tp_h <= d[0];
         hook_raw <= ~d[0];
         cyc(HS - 1);
         hook_raw <= d[0];
         cyc(20);
         clr2();
         @(negedge core_clk);
         chk("hook short burst", 1'b0, hk_flag);
         @(posedge core_clk);
         hook_raw <= ~d[0];
         lat(1);
         chk("hook latency", 1'b1, n > HS && n <= HS + 6);
         @(posedge core_clk);
      end
      hook_db <= 1'b1;
      tp_h <= 1'b0;
      cyc(3);
      clr2();
      hook_raw <= 1'b1;
      lat(1);
      chk("hook debounce latency", 1'b1, n > HS + DB && n <= HS + DB + 8);
      @(posedge core_clk);
      tp_i <= 1'b0;
      clr2();
      ins_raw <= 1'b1;
      lat(0);
      chk("insert latency", 1'b1, n >= 1 && n <= 3);
      @(posedge core_clk);
      ins_db <= 1'b1;
      ins_raw <= 1'b0;
      cyc(25);
      clr2();
      ins_raw <= 1'b1;
      cyc(DB - 2);
      ins_raw <= 1'b0;
      cyc(20);
      @(negedge core_clk);
      chk("insert glitch", 1'b0, ins_flag);
      @(posedge core_clk);
      ins_raw <= 1'b1;
      lat(0);
      chk("insert debounce latency", 1'b1, n > DB && n <= DB + 6);
      // clear held while frozen must not land until the enable returns
      @(posedge core_clk);
      ce <= 1'b0;
      tc_i <= 1'b1;
      cyc(3);
      @(negedge core_clk);
      chk("frozen flag", 1'b1, ins_flag);
      @(posedge core_clk);
      ce <= 1'b1;
      cyc(1);
      tc_i <= 1'b0;
      cyc(2);
      @(negedge core_clk);
      chk("flag after thaw", 1'b0, ins_flag);
      @(posedge core_clk);
      rst_b <= 1'b0;
      @(negedge core_clk);
      chk("flags after reset", 1'b0, ins_flag | hk_flag | ins_st);
      @(posedge core_clk);
      rst_b <= 1'b1;
      ins_raw <= 1'b0;
      hook_raw <= 1'b0;
      cyc(30);
      clr2();
      auto_en <= 1'b1;
      slow <= 1'b1;
      // insert, press, release, removal, with a one-cycle jack bounce
      for (int s = 0; s < 4; s++) begin
         if (s == 1 || s == 2) hook_raw <= (s < 2);
         else begin
            ins_raw <= (s < 2);
            cyc(1);
            ins_raw <= (s >= 2);
            cyc(1);
            ins_raw <= (s < 2);
         end
         cyc(40);
         @(negedge core_clk);
         chk("host insert polarity", s < 3, ins_pol);
         chk("host hook polarity", s == 1, hk_pol);
         chk("flags cleared", 1'b0, ins_flag | hk_flag);
         @(posedge core_clk);
      end
      end_of_test();
   end
endmodule

// ---- verif/mihd_host.sv ----
// host model: polls one event flag, flips its polarity, then clears it
`timescale 1ns/1ps
module mihd_host (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic auto_en,
   input  wire logic slow,
   input  wire logic flag,
   input  wire logic tb_pol,
   input  wire logic tb_clr,
   output logic      pol,
   output logic      clr
);
   logic [2:0] wait_ff;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pol <= 1'b0;
         clr <= 1'b0;
         wait_ff <= 3'h0;
      end else if (!auto_en) begin
         pol <= tb_pol;
         clr <= tb_clr;
      end else if (clr) begin
         clr <= 1'b0;
      end else if (wait_ff != 3'h0) begin
         // slow mode rides out contact bounce before clearing
         wait_ff <= wait_ff - 3'h1;
         clr <= (wait_ff == 3'h1);
      end else if (flag) begin
         pol <= ~pol;
         wait_ff <= slow ? 3'h7 : 3'h1;
      end
   end
endmodule
